/* File: ioc_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef IOC_REGS_SVH
`define IOC_REGS_SVH

// ============================================================
// Register map (byte addresses on APB)
`define IOC_OFS_CONTROL 8'h00
`define IOC_OFS_TRIM 8'h04
`define IOC_ADDR_W 8

// ============================================================
// Field positions
`define IOC_RATE_LSB 4
`define IOC_RATE_MSB 5
`define IOC_HF_FLAG_BIT 2
`define IOC_LF_FLAG_BIT 1
`define IOC_TRIM_MSB 4

// ============================================================
// Reset values and rate codes
`define IOC_RATE_RESET 2'h1
`define IOC_TRIM_RESET 5'h00
`define IOC_RATE_8M 2'h3
`define IOC_RATE_4M 2'h2
`define IOC_RATE_1M 2'h1
`define IOC_RATE_LF 2'h0
`define IOC_TRIM_SIGN 5'h10

// ============================================================
// Timing
`define IOC_CORE_CLK_KHZ 25000
`define IOC_STARTUP_US 10
`define IOC_STARTUP_CYCLES \
  ((`IOC_STARTUP_US * `IOC_CORE_CLK_KHZ + 999) / 1000)
`define IOC_BASE_CLK_KHZ 8000
`define IOC_SHIFT_BASE_CYCLES 8
`define IOC_SHIFT_LIMIT_CYCLES \
  ((`IOC_SHIFT_BASE_CYCLES * `IOC_CORE_CLK_KHZ) / `IOC_BASE_CLK_KHZ)
`define IOC_TRIM_STEP 4
`define IOC_LF_CLK_KHZ 31
`define IOC_SWITCH_GAP_CYCLES \
  ((`IOC_CORE_CLK_KHZ + `IOC_LF_CLK_KHZ - 1) / `IOC_LF_CLK_KHZ)

`endif

/* File: ioc_pkg.sv */
// Types shared by the oscillator control block
package ioc_pkg;

  typedef enum logic [2:0] {
    IOC_SRC_LF,
    IOC_SRC_HF1,
    IOC_SRC_HF4,
    IOC_SRC_HF8,
    IOC_SRC_EXT
  } ioc_src_e;

  typedef enum logic {
    IOC_SW_RUN,
    IOC_SW_DRAIN
  } ioc_sw_state_e;

  typedef logic [1:0] ioc_rate_t;
  typedef logic [4:0] ioc_trim_t;

endpackage

/* File: ioc_trim_ramp.sv */
// Walks the applied trim code toward the programmed value in small steps
`timescale 1ns/1ps
`include "ioc_regs.svh"

module ioc_trim_ramp #(
  parameter int STEP = `IOC_TRIM_STEP,
  parameter int LIMIT = `IOC_SHIFT_LIMIT_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire ioc_pkg::ioc_trim_t target_i,
  output ioc_pkg::ioc_trim_t code_o
);
  import ioc_pkg::*;

  // Worst case is a full swing of 31 codes
  if (STEP < 1 || (31 + STEP - 1) / STEP > LIMIT) begin : g_bad_step
    $error("Trim step cannot finish a full swing in time");
  end

  ioc_trim_t goal;
  logic [5:0] up_gap;
  logic [5:0] dn_gap;
  logic [5:0] step_w;

  // Offset binary keeps the code monotonic in frequency
  assign goal = target_i ^ `IOC_TRIM_SIGN; // [RULE8]
  assign up_gap = {1'b0, goal} - {1'b0, code_o};
  assign dn_gap = {1'b0, code_o} - {1'b0, goal};
  assign step_w = 6'(STEP);

  // ============================================================
  // Ramp
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_o <= `IOC_TRIM_SIGN;
    end else if (goal > code_o) begin
      if (up_gap > step_w) begin
        code_o <= code_o + 5'(STEP); // [RULE1]
      end else begin
        code_o <= goal;
      end
    end else if (goal < code_o) begin
      if (dn_gap > step_w) begin
        code_o <= code_o - 5'(STEP); // [RULE1]
      end else begin
        code_o <= goal;
      end
    end
  end

endmodule // ioc_trim_ramp

/* File: ioc_clk_switch.sv */
// Break-before-make selector for the system clock source
`timescale 1ns/1ps
`include "ioc_regs.svh"

module ioc_clk_switch #(
  parameter int GAP = `IOC_SWITCH_GAP_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire ioc_pkg::ioc_src_e req_i,
  input wire logic req_ready_i,
  output ioc_pkg::ioc_src_e src_o,
  output logic gate_o
);
  import ioc_pkg::*;

  localparam int CW = $clog2(GAP + 1);

  if (GAP < 1) begin : g_bad_gap
    $error("Switch gap must be at least one cycle");
  end

  ioc_sw_state_e state;
  logic [CW-1:0] cnt;

  // ============================================================
  // Switch sequence
  // The gate stays low for one slowest-clock period so that no
  // shortened pulse of the old source leaks through.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= IOC_SW_DRAIN;
      cnt <= '0;
      src_o <= IOC_SRC_HF1;
      gate_o <= 1'b0;
    end else begin
      case (state)
        IOC_SW_RUN: begin
          if (req_i != src_o) begin
            gate_o <= 1'b0; // [RULE13]
            cnt <= CW'(GAP - 1);
            state <= IOC_SW_DRAIN;
          end
        end
        IOC_SW_DRAIN: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (req_ready_i) begin
            src_o <= req_i; // [RULE13]
            gate_o <= 1'b1;
            state <= IOC_SW_RUN;
          end
        end
        default: begin
          state <= IOC_SW_DRAIN;
        end
      endcase
    end
  end

endmodule // ioc_clk_switch

/* File: ioc_top.sv */
// Internal oscillator control: registers, start-up hold, source select
// Notes on behaviour
// [RULE1] Trim change moves the oscillator gradually, within eight base cycles.
// [RULE2] Power-up and wake hold operation for a fixed 10 us delay.
// [RULE3] Rate select bits 5-4: 11=8 MHz, 10=4 MHz, 01=1 MHz, 00=31 kHz.
// [RULE4] Rate select loads 1 MHz at power-on, kept across other resets.
// [RULE5] Bit 2 reads 1 while the high-frequency oscillator runs stable.
// [RULE6] Bit 1 reads 1 while the low-frequency oscillator runs stable.
// [RULE7] Trim holds 5-bit two's complement, zero at power-on, kept otherwise.
// [RULE8] Trim zero is calibrated; positive raises, negative lowers, monotonic.
// [RULE9] Execution continues during a trim shift; no completion flag exists.
// [RULE10] Unimplemented control and trim bits read zero and ignore writes.
// [RULE11] Config bit set picks the external clock, clear picks internal.
// [RULE12] Trim acts on high-frequency rates only, never on 31 kHz.
// [RULE13] Rate changes switch the clock without shortened or glitched pulses.
`timescale 1ns/1ps
`include "ioc_regs.svh"

module ioc_top #(
  parameter int STARTUP_CYCLES = `IOC_STARTUP_CYCLES,
  parameter int SWITCH_GAP = `IOC_SWITCH_GAP_CYCLES,
  parameter int TRIM_STEP = `IOC_TRIM_STEP
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`IOC_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic clock_source_config_bit_i,
  input wire logic wake_i,
  input wire logic hf_osc_ready_i,
  input wire logic lf_osc_ready_i,
  output logic hf_osc_en_o,
  output logic lf_osc_en_o,
  output ioc_pkg::ioc_src_e clk_src_sel_o,
  output logic clk_gate_o,
  output ioc_pkg::ioc_trim_t hf_trim_code_o,
  output logic core_run_o
);
  import ioc_pkg::*;

  localparam int SW = $clog2(STARTUP_CYCLES + 1);

  if (STARTUP_CYCLES < 1) begin : g_bad_startup
    $error("Start-up delay must be at least one cycle");
  end

  // ============================================================
  // Helpers
  function automatic ioc_src_e pick_source(input logic ext,
                                           input ioc_rate_t rate);
    ioc_src_e s;
    s = IOC_SRC_HF1;
    if (ext) begin
      s = IOC_SRC_EXT; // [RULE11]
    end else if (rate == `IOC_RATE_8M) begin
      s = IOC_SRC_HF8; // [RULE3]
    end else if (rate == `IOC_RATE_4M) begin
      s = IOC_SRC_HF4;
    end else if (rate == `IOC_RATE_1M) begin
      s = IOC_SRC_HF1;
    end else begin
      s = IOC_SRC_LF;
    end
    return s;
  endfunction

  function automatic logic addr_is(input logic [`IOC_ADDR_W-1:0] a,
                                   input logic [`IOC_ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // ============================================================
  // State
  ioc_rate_t rate_sel;
  ioc_trim_t trim_value;
  logic hf_flag;
  logic lf_flag;
  logic ext_mode;
  logic strap_taken;
  logic [SW-1:0] hold_cnt;
  ioc_src_e want_src;
  logic want_ready;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] next_rdata;

  assign want_src = pick_source(ext_mode, rate_sel);

  always_comb begin
    case (want_src)
      IOC_SRC_EXT: want_ready = 1'b1;
      IOC_SRC_LF: want_ready = lf_osc_ready_i;
      default: want_ready = hf_osc_ready_i;
    endcase
  end

  // ============================================================
  // APB slave: no wait states, answer in the first access cycle
  assign addr_ok = addr_is(paddr_i, `IOC_OFS_CONTROL) ||
                   addr_is(paddr_i, `IOC_OFS_TRIM);
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i && addr_ok;
  assign rd_en = psel_i && !penable_i && !pwrite_i;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (psel_i && !penable_i) begin
      pready_o <= 1'b1;
      pslverr_o <= !addr_ok;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (addr_is(paddr_i, `IOC_OFS_CONTROL)) begin
      next_rdata[`IOC_RATE_MSB:`IOC_RATE_LSB] = rate_sel;
      next_rdata[`IOC_HF_FLAG_BIT] = hf_flag; // [RULE5]
      next_rdata[`IOC_LF_FLAG_BIT] = lf_flag; // [RULE6]
    end else if (addr_is(paddr_i, `IOC_OFS_TRIM)) begin
      next_rdata[`IOC_TRIM_MSB:0] = trim_value;
    end
  end

  // Bits not assigned above stay zero [RULE10]
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_o <= next_rdata;
    end
  end

  // ============================================================
  // Control registers: only the power-on reset loads their reset values
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rate_sel <= `IOC_RATE_RESET; // [RULE4]
    end else if (wr_en && addr_is(paddr_i, `IOC_OFS_CONTROL)) begin
      rate_sel <= pwdata_i[`IOC_RATE_MSB:`IOC_RATE_LSB]; // [RULE3] [RULE10]
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trim_value <= `IOC_TRIM_RESET; // [RULE7]
    end else if (wr_en && addr_is(paddr_i, `IOC_OFS_TRIM)) begin
      trim_value <= pwdata_i[`IOC_TRIM_MSB:0]; // [RULE7] [RULE10]
    end
  end

  // ============================================================
  // Status flags: running means enabled and reported stable
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hf_flag <= 1'b0; // [RULE5]
      lf_flag <= 1'b0; // [RULE6]
    end else begin
      hf_flag <= hf_osc_en_o && hf_osc_ready_i; // [RULE5]
      lf_flag <= lf_osc_en_o && lf_osc_ready_i; // [RULE6]
    end
  end

  // ============================================================
  // Clock source strap, caught once after the power-on release
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_mode <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      ext_mode <= clock_source_config_bit_i; // [RULE11]
      strap_taken <= 1'b1;
    end
  end

  // ============================================================
  // Oscillator enables
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hf_osc_en_o <= 1'b0;
      lf_osc_en_o <= 1'b0;
    end else begin
      hf_osc_en_o <= !ext_mode && rate_sel != `IOC_RATE_LF; // [RULE11]
      lf_osc_en_o <= !ext_mode && rate_sel == `IOC_RATE_LF;
    end
  end

  // ============================================================
  // Start-up hold after power-on and after wake from sleep
  // Applies equally to internal and external modes.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_cnt <= SW'(STARTUP_CYCLES); // [RULE2]
      core_run_o <= 1'b0;
    end else if (wake_i) begin
      hold_cnt <= SW'(STARTUP_CYCLES); // [RULE2]
      core_run_o <= 1'b0;
    end else if (hold_cnt != '0) begin
      hold_cnt <= hold_cnt - 1'b1;
      core_run_o <= hold_cnt == SW'(1); // [RULE2]
    end
  end

  // ============================================================
  // Trim path
  // The ramp code drives only the high-frequency oscillator, so the
  // 31 kHz source is never shifted. Nothing here feeds core_run_o:
  // the core keeps running while the code settles, and no done
  // indication is offered. [RULE12] [RULE9]
  ioc_trim_ramp #(
    .STEP(TRIM_STEP),
    .LIMIT(`IOC_SHIFT_LIMIT_CYCLES)
  ) u_ramp (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .target_i(trim_value),
    .code_o(hf_trim_code_o)
  );

  // ============================================================
  // System clock selection
  // Waits for the new source to be stable before opening the gate,
  // so a switch to a cold oscillator does not pass its start-up noise.
  ioc_clk_switch #(
    .GAP(SWITCH_GAP)
  ) u_switch (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .req_i(want_src),
    .req_ready_i(want_ready && strap_taken),
    .src_o(clk_src_sel_o),
    .gate_o(clk_gate_o)
  );

endmodule // ioc_top

/* File: ioc_chk.sv */
// Port-level assertions for the oscillator control block
`timescale 1ns/1ps
module ioc_chk
  import ioc_pkg::*;
#(
  parameter int STARTUP_CYCLES = 250,
  parameter int SWITCH_GAP = 807
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic clock_source_config_bit_i,
  input wire logic wake_i,
  input wire ioc_pkg::ioc_src_e clk_src_sel_o,
  input wire logic clk_gate_o,
  input wire ioc_pkg::ioc_trim_t hf_trim_code_o,
  input wire logic core_run_o
);
  // ============================================================
  // Helper counters
  logic [8:0] run_cnt;
  logic [9:0] gap_cnt;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) run_cnt <= 9'h000;
    else if (wake_i) run_cnt <= 9'h000;
    else if (run_cnt != 9'h1FF) run_cnt <= run_cnt + 9'h001;
  end
  // Reset counts as a long gap, the first opening needs no wait
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) gap_cnt <= 10'(SWITCH_GAP);
    else if (clk_gate_o) gap_cnt <= 10'h000;
    else if (gap_cnt != 10'h3FF) gap_cnt <= gap_cnt + 10'h001;
  end
  // ============================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  chk_trim_settle: assert property (
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h04
    |-> ##[1:24] hf_trim_code_o == (pwdata_i[4:0] ^ 5'h10))
    else $error("trim code missed its target");
  chk_trim_step: assert property (
    5'(hf_trim_code_o - $past(hf_trim_code_o)) <= 5'h04 ||
    5'($past(hf_trim_code_o) - hf_trim_code_o) <= 5'h04)
    else $error("trim code jumped");
  chk_ctl_rsv: assert property (
    pready_o && !pwrite_i && paddr_i == 8'h00
    |-> (prdata_o & 32'hFFFF_FFC9) == 32'h0000_0000)
    else $error("control spare bits not zero");
  chk_trim_rsv: assert property (
    pready_o && !pwrite_i && paddr_i == 8'h04
    |-> (prdata_o & 32'hFFFF_FFE0) == 32'h0000_0000)
    else $error("trim spare bits not zero");
  chk_ext_src: assert property (
    clk_gate_o && clock_source_config_bit_i |-> clk_src_sel_o == IOC_SRC_EXT)
    else $error("strap set but source not external");
  chk_sel_gated: assert property (
    clk_src_sel_o != $past(clk_src_sel_o) |-> !$past(clk_gate_o))
    else $error("source moved while gate open");
  chk_gap_len: assert property (
    $rose(clk_gate_o) |-> gap_cnt >= SWITCH_GAP)
    else $error("gate reopened too soon");
  chk_run_early: assert property (
    core_run_o |-> run_cnt >= STARTUP_CYCLES)
    else $error("run before hold ended");
  chk_run_late: assert property (
    run_cnt > STARTUP_CYCLES |-> core_run_o)
    else $error("run late after hold");
endmodule // ioc_chk

/* File: ioc_tb_top.sv */
// Directed self-checking bench for the oscillator control block
`timescale 1ns/1ps
module ioc_tb_top;
  import ioc_pkg::*;
  localparam int SU = 5;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sys_rst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic clock_source_config_bit_i = 1'b0;
  logic wake_i = 1'b0;
  logic hf_osc_ready_i = 1'b1;
  logic lf_osc_ready_i = 1'b1;
  logic hf_osc_en_o;
  logic lf_osc_en_o;
  ioc_src_e clk_src_sel_o;
  logic clk_gate_o;
  ioc_trim_t hf_trim_code_o;
  logic core_run_o;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  always #20 core_clk_i = ~core_clk_i;
  // Short hold and gap keep the run brief
  ioc_top #(.STARTUP_CYCLES(SU), .SWITCH_GAP(4), .TRIM_STEP(4)) dut_u (
    .core_clk_i, .rst_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .clock_source_config_bit_i, .wake_i, .hf_osc_ready_i,
    .lf_osc_ready_i, .hf_osc_en_o, .lf_osc_en_o, .clk_src_sel_o,
    .clk_gate_o, .hf_trim_code_o, .core_run_o);
  // ============================================================
  // Shared tasks
  task automatic cmp(string nm, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(string nm, logic [7:0] a, logic [31:0] m,
                     logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    cmp(nm, x, r & m);
  endtask
  task automatic wgate();
    repeat (2) @(posedge core_clk_i);
    while (clk_gate_o !== 1'b1) @(posedge core_clk_i);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_por();
    wgate();
    rdc("ctl", 8'h00, 32'hFFFF_FFFD, 32'h0000_0014);
    rdc("trim", 8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
    cmp("code", 32'h0000_0010, hf_trim_code_o);
    cmp("src", IOC_SRC_HF1, clk_src_sel_o);
    $display("t_por done");
  endtask
  task automatic t_rates();
    logic [31:0] f;
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'hFFFF_FFCF | (32'(i) << 4));
      wgate();
      f = (i == 0) ? 32'h0000_0002 : 32'h0000_0004;
      cmp("src", 32'(i), clk_src_sel_o);
      rdc("rate", 8'h00, 32'hFFFF_FFF9, 32'(i) << 4);
      rdc("flag", 8'h00, f, f);
      cmp("lfen", 32'(i == 0), lf_osc_en_o);
      cmp("hfen", 32'(i != 0), hf_osc_en_o);
    end
    $display("t_rates done");
  endtask
  task automatic t_trim();
    wr(8'h04, 32'hFFFF_FFEF);
    repeat (10) @(posedge core_clk_i);
    cmp("code", 32'h0000_001F, hf_trim_code_o);
    rdc("trim", 8'h04, 32'hFFFF_FFFF, 32'h0000_000F);
    cmp("run", 32'h0000_0001, core_run_o);
    wr(8'h04, 32'h0000_0010);
    repeat (10) @(posedge core_clk_i);
    cmp("code", 32'h0000_0000, hf_trim_code_o);
    $display("t_trim done");
  endtask
  task automatic t_bad();
    logic [31:0] r;
    logic e;
    wr(8'h08, 32'h0000_0000);
    apb(1'b0, 8'h08, 32'h0000_0000, r, e);
    cmp("err", 32'h0000_0001, e);
    cmp("rd", 32'h0000_0000, r);
    rdc("ctl", 8'h00, 32'h0000_0030, 32'h0000_0030);
    $display("t_bad done");
  endtask
  task automatic t_sys();
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rdc("ctl", 8'h00, 32'h0000_0030, 32'h0000_0030);
    rdc("trim", 8'h04, 32'h0000_001F, 32'h0000_0010);
    hf_osc_ready_i <= 1'b0;
    rdc("hfunst", 8'h00, 32'h0000_0004, 32'h0000_0000);
    hf_osc_ready_i <= 1'b1;
    rdc("hfst", 8'h00, 32'h0000_0004, 32'h0000_0004);
    $display("t_sys done");
  endtask
  task automatic t_wake();
    @(posedge core_clk_i);
    wake_i <= 1'b1;
    @(posedge core_clk_i);
    wake_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    cmp("hold", 32'h0000_0000, core_run_o);
    repeat (SU + 2) @(posedge core_clk_i);
    cmp("run", 32'h0000_0001, core_run_o);
    $display("t_wake done");
  endtask
  task automatic t_ext();
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    clock_source_config_bit_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wgate();
    cmp("src", IOC_SRC_EXT, clk_src_sel_o);
    cmp("hfen", 32'h0000_0000, hf_osc_en_o);
    cmp("lfen", 32'h0000_0000, lf_osc_en_o);
    rdc("ctl", 8'h00, 32'h0000_0030, 32'h0000_0010);
    rdc("trim", 8'h04, 32'h0000_001F, 32'h0000_0000);
    $display("t_ext done");
  endtask
  // ============================================================
  // Sequence and hang guard
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_por();
    t_rates();
    t_trim();
    t_bad();
    t_sys();
    t_wake();
    t_ext();
    give_verdict();
  end
endmodule // ioc_tb_top
bind ioc_top ioc_chk #(.STARTUP_CYCLES(STARTUP_CYCLES),
  .SWITCH_GAP(SWITCH_GAP)) chk_u (.core_clk_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .clock_source_config_bit_i, .wake_i, .clk_src_sel_o, .clk_gate_o,
  .hf_trim_code_o, .core_run_o);
